// file: core/ssx_alu_cfg.svh
// Purpose: constants for the subtract/swap/xor execution datapath
// Assumes: 8-bit data, 7-bit file address
// Notes: widths, bit positions, destination codes and reset values only
`ifndef SSX_ALU_CFG_SVH
`define SSX_ALU_CFG_SVH
`define SSX_DATA_W 8
`define SSX_ADDR_W 7
`define SSX_NIB_LO_MSB 3
`define SSX_NIB_HI_LSB 4
`define SSX_DEST_W 1'b0
`define SSX_DEST_F 1'b1
`define SSX_W_RST 8'h00
`define SSX_STAT_RST 3'b000
`endif

// file: core/ssx_alu_pkg.sv
// Purpose: types for the subtract/swap/xor execution datapath
// Assumes: decoder presents one opcode per cycle with i_op_valid
// Notes: one-hot operation codes
package ssx_alu_pkg;
    typedef enum logic [4:0] {
        SSX_SUB_FROM_LITERAL_OP = 5'b0_0001,
        SSX_SUB_FROM_FILE_OP    = 5'b0_0010,
        SSX_NIBBLE_EXCHANGE_OP  = 5'b0_0100,
        SSX_XOR_FILE_OP         = 5'b0_1000,
        SSX_XOR_LITERAL_OP      = 5'b1_0000
    } ssx_op_t;
endpackage

// file: core/ssx_alu.sv
// Purpose: execution of five byte instructions with flag and destination handling
// Assumes: file register array and decoder on same clock; one op per valid cycle
// Notes: results and flags are registered, visible one cycle after the op
`timescale 1ns/100ps
`include "ssx_alu_cfg.svh"
module ssx_alu (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_op_valid,
    input wire logic [4:0] i_op,
    input wire logic i_dest_sel,
    input wire logic [6:0] i_file_addr,
    input wire logic [7:0] i_file_data,
    input wire logic [7:0] i_literal,
    output logic [7:0] o_work_reg,
    output logic o_carry_flag,
    output logic o_digit_carry_flag,
    output logic o_zero_flag,
    output logic o_file_we,
    output logic [6:0] o_file_addr,
    output logic [7:0] o_file_wdata
);
    ////////////////////////////////////////////////////////////////////////////
    logic rst_s1_q;
    logic rst_s2_q;
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire logic rst_n = rst_s2_q;

    ////////////////////////////////////////////////////////////////////////////
    // subtraction as a + ~b + 1; carry outs are the no-borrow flags
    function automatic logic [9:0] sub_nb(input logic [7:0] a, input logic [7:0] b);
        logic [4:0] lo;
        logic [8:0] full;
        lo = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        full = {1'b0, a} + {1'b0, ~b} + 9'h001;
        return {full[8], lo[4], full[7:0]};
    endfunction

    ssx_alu_pkg::ssx_op_t op;
    assign op = ssx_alu_pkg::ssx_op_t'(i_op);
    logic [9:0] sub_lit;
    logic [9:0] sub_file;
    assign sub_lit = sub_nb(i_literal, o_work_reg);
    assign sub_file = sub_nb(i_file_data, o_work_reg);

    logic [7:0] res_d;
    logic to_file_d;
    logic flags_c_d;
    logic upd_cdc_d;
    logic upd_z_d;
    logic c_d;
    logic dc_d;
    always_comb begin
        res_d = 8'h00;
        to_file_d = 1'b0;
        upd_cdc_d = 1'b0;
        upd_z_d = 1'b0;
        c_d = o_carry_flag;
        dc_d = o_digit_carry_flag;
        unique case (op)
            ssx_alu_pkg::SSX_SUB_FROM_LITERAL_OP: begin
                res_d = sub_lit[7:0];
                c_d = sub_lit[9];
                dc_d = sub_lit[8];
                upd_cdc_d = 1'b1;
                upd_z_d = 1'b1;
            end
            ssx_alu_pkg::SSX_SUB_FROM_FILE_OP: begin
                res_d = sub_file[7:0];
                c_d = sub_file[9];
                dc_d = sub_file[8];
                to_file_d = (i_dest_sel == `SSX_DEST_F);
                upd_cdc_d = 1'b1;
                upd_z_d = 1'b1;
            end
            ssx_alu_pkg::SSX_NIBBLE_EXCHANGE_OP: begin
                res_d = {i_file_data[`SSX_NIB_LO_MSB:0], i_file_data[7:`SSX_NIB_HI_LSB]};
                to_file_d = (i_dest_sel == `SSX_DEST_F);
            end
            ssx_alu_pkg::SSX_XOR_FILE_OP: begin
                res_d = o_work_reg ^ i_file_data;
                to_file_d = (i_dest_sel == `SSX_DEST_F);
                upd_z_d = 1'b1;
            end
            ssx_alu_pkg::SSX_XOR_LITERAL_OP: begin
                res_d = o_work_reg ^ i_literal;
                upd_z_d = 1'b1;
            end
            // illegal codes do nothing
            default: begin
                res_d = 8'h00;
            end
        endcase
    end
    assign flags_c_d = upd_cdc_d;

    ////////////////////////////////////////////////////////////////////////////
    logic legal_op;
    assign legal_op = i_op_valid && ($countones(i_op) == 1);

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_work_reg <= `SSX_W_RST;
            o_file_we <= 1'b0;
            o_file_addr <= 7'h00;
            o_file_wdata <= 8'h00;
        end else begin
            o_file_we <= legal_op && to_file_d;
            o_file_addr <= i_file_addr;
            o_file_wdata <= res_d;
            if (legal_op && !to_file_d) begin
                o_work_reg <= res_d;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {o_carry_flag, o_digit_carry_flag, o_zero_flag} <= `SSX_STAT_RST;
        end else if (legal_op) begin
            if (flags_c_d) begin
                o_carry_flag <= c_d;
                o_digit_carry_flag <= dc_d;
            end
            if (upd_z_d) begin
                o_zero_flag <= (res_d == 8'h00);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!rst_n);

    sub_lit_result_a: assert property (
        i_op_valid && i_op == 5'b0_0001 |=> o_work_reg == $past(i_literal) - $past(o_work_reg))
        else $error("literal subtract result wrong");
    sub_file_result_a: assert property (
        i_op_valid && i_op == 5'b0_0010 && i_dest_sel
        |=> o_file_we && o_file_wdata == $past(i_file_data) - $past(o_work_reg))
        else $error("file subtract result wrong");
    dest_work_hold_a: assert property (
        i_op_valid && i_op != 5'b0_0001 && i_op != 5'b1_0000 && i_dest_sel
        |=> $stable(o_work_reg))
        else $error("working register written with file destination");
    dest_file_none_a: assert property (
        i_op_valid && !i_dest_sel |=> !o_file_we)
        else $error("file written with working destination");
    swap_nibbles_a: assert property (
        i_op_valid && i_op == 5'b0_0100 && !i_dest_sel
        |=> o_work_reg == {$past(i_file_data[3:0]), $past(i_file_data[7:4])})
        else $error("nibble swap wrong");
    swap_flags_keep_a: assert property (
        i_op_valid && i_op == 5'b0_0100
        |=> $stable({o_carry_flag, o_digit_carry_flag, o_zero_flag}))
        else $error("swap changed flags");
    xor_file_zero_a: assert property (
        i_op_valid && i_op == 5'b0_1000
        |=> $stable(o_carry_flag) && o_zero_flag == ($past(o_work_reg) == $past(i_file_data)))
        else $error("xor file flags wrong");
    xor_lit_flags_a: assert property (
        i_op_valid && i_op == 5'b1_0000
        |=> $stable(o_digit_carry_flag)
            && o_zero_flag == ($past(o_work_reg) == $past(i_literal)))
        else $error("xor literal flags wrong");
    xor_lit_result_a: assert property (
        i_op_valid && i_op == 5'b1_0000
        |=> o_work_reg == ($past(o_work_reg) ^ $past(i_literal)) && !o_file_we)
        else $error("xor literal result wrong");
    xor_file_dest_a: assert property (
        i_op_valid && i_op == 5'b0_1000 && i_dest_sel
        |=> o_file_we && o_file_wdata == ($past(o_work_reg) ^ $past(i_file_data)))
        else $error("xor file result wrong");
    swap_file_dest_a: assert property (
        i_op_valid && i_op == 5'b0_0100 && i_dest_sel
        |=> o_file_we && o_file_wdata == {$past(i_file_data[3:0]), $past(i_file_data[7:4])})
        else $error("nibble swap to file wrong");
    sub_file_work_a: assert property (
        i_op_valid && i_op == 5'b0_0010 && !i_dest_sel
        |=> !o_file_we && o_work_reg == $past(i_file_data) - $past(o_work_reg))
        else $error("file subtract to working register wrong");
    sub_borrow_flags_a: assert property (
        i_op_valid && i_op == 5'b0_0001
        |=> o_carry_flag == ($past(i_literal) >= $past(o_work_reg))
            && o_digit_carry_flag == ($past(i_literal[3:0]) >= $past(o_work_reg[3:0]))
            && o_zero_flag == ($past(i_literal) == $past(o_work_reg)))
        else $error("subtract borrow flags wrong");
    sub_file_flags_a: assert property (
        i_op_valid && i_op == 5'b0_0010
        |=> o_carry_flag == ($past(i_file_data) >= $past(o_work_reg))
            && o_digit_carry_flag == ($past(i_file_data[3:0]) >= $past(o_work_reg[3:0]))
            && o_zero_flag == ($past(i_file_data) == $past(o_work_reg)))
        else $error("file subtract flags wrong");
    file_addr_echo_a: assert property (
        1'b1 |=> o_file_addr == $past(i_file_addr))
        else $error("file address not echoed");
    refused_op_hold_a: assert property (
        !i_op_valid || $countones(i_op) != 1
        |=> !o_file_we && $stable(o_work_reg)
            && $stable({o_carry_flag, o_digit_carry_flag, o_zero_flag}))
        else $error("refused op changed state");

    sub_zero_c: cover property (i_op_valid && i_op == 5'b0_0001 ##1 o_zero_flag);
    sub_file_c: cover property (i_op_valid && i_op == 5'b0_0010 && i_dest_sel);
    swap_c: cover property (i_op_valid && i_op == 5'b0_0100 && !i_dest_sel);
    xor_c: cover property (i_op_valid && i_op == 5'b0_1000 ##1 i_op_valid && i_op == 5'b1_0000);
endmodule

// file: test/ssx_file_model.sv
// Purpose: file register array on the far side of the datapath
// Assumes: combinational read, write on the rising edge
// Notes: starts from a fixed pattern that the bench mirrors
`timescale 1ns/100ps
module ssx_file_model (
    input wire logic i_core_clk,
    input wire logic [6:0] i_addr,
    input wire logic i_we,
    input wire logic [6:0] i_waddr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem_q [128];
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem_q[i] = 8'(i * 29 + 7);
        end
    end
    // bypass so a write lands before the next op reads the same cell
    assign o_rdata = (i_we && i_waddr == i_addr) ? i_wdata : mem_q[i_addr];
    always @(posedge i_core_clk) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
    end
endmodule

// file: test/ssx_alu_tb.sv
// Purpose: random and boundary op stream against a mirrored datapath
// Assumes: result visible one cycle after the op is taken
// Notes: index 5 of the op table is an illegal code
`timescale 1ns/100ps
module ssx_alu_tb;
    typedef struct packed {
        logic [7:0] w;
        logic [2:0] f;
        logic we;
        logic [7:0] d;
        logic [6:0] a;
    } ssx_note_t;
    logic clk = 0, rst_n = 0, vld = 0, dsel = 0, cry, dig, zro, we;
    logic [4:0] op = 5'h00;
    logic [6:0] fa = 7'h00, wa;
    logic [7:0] lit = 8'h00, fd, w, wd, ew = 8'h00;
    logic [2:0] ef = 3'h0;
    logic [7:0] mir [128];
    logic [4:0] ops [6] = '{ssx_alu_pkg::SSX_SUB_FROM_LITERAL_OP,
        ssx_alu_pkg::SSX_SUB_FROM_FILE_OP, ssx_alu_pkg::SSX_NIBBLE_EXCHANGE_OP,
        ssx_alu_pkg::SSX_XOR_FILE_OP, ssx_alu_pkg::SSX_XOR_LITERAL_OP, 5'h03};
    ssx_note_t q [$];
    ssx_note_t n;
    int fails = 0, num_checks = 0;
    ssx_alu dut_u (.i_core_clk(clk), .i_arst_n(rst_n), .i_op_valid(vld), .i_op(op),
        .i_dest_sel(dsel), .i_file_addr(fa), .i_file_data(fd), .i_literal(lit), .o_work_reg(w),
        .o_carry_flag(cry), .o_digit_carry_flag(dig), .o_zero_flag(zro), .o_file_we(we),
        .o_file_addr(wa), .o_file_wdata(wd));
    ssx_file_model mdl_u (.i_core_clk(clk), .i_addr(fa), .i_we(we), .i_waddr(wa),
        .i_wdata(wd), .o_rdata(fd));
    initial forever #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk_data(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: data %h, wanted %h", $time, g, e);
        end
    endtask
    task automatic chk_flags(input logic [3:0] g, input logic [3:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: flags/we %b, wanted %b", $time, g, e);
        end
    endtask
    task automatic chk_addr(input logic [6:0] g, input logic [6:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: file address %h, wanted %h", $time, g, e);
        end
    endtask
    task report_and_stop;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic run_op(input logic v, input int k, input logic d, input logic [6:0] a,
        input logic [7:0] l);
        logic [7:0] s, r;
        ssx_note_t m;
        s = (k == 0 || k == 4) ? l : mir[a];
        r = s ^ ew;
        m = '{w: ew, f: ef, we: 1'b0, d: 8'h00, a: a};
        if (v && k < 5) begin
            if (k < 2) begin
                r = s - ew;
                m.f = {s >= ew, s[3:0] >= ew[3:0], r == 8'h00};
            end
            if (k == 2) r = {s[3:0], s[7:4]};
            if (k > 2) m.f[0] = (r == 8'h00);
            if (d && k > 0 && k < 4) begin
                m.we = 1'b1;
                m.d = r;
                mir[a] = r;
            end else m.w = r;
        end
        ew = m.w;
        ef = m.f;
        vld <= v;
        op <= ops[k];
        dsel <= d;
        fa <= a;
        lit <= l;
        @(posedge clk);
        q.push_back(m);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        if (q.size() > 0) begin
            n = q.pop_front();
            chk_data(w, n.w);
            chk_flags({cry, dig, zro, we}, {n.f, n.we});
            if (n.we) chk_data(wd, n.d);
            chk_addr(wa, n.a);
        end
    end
    initial begin
        for (int i = 0; i < 128; i++) mir[i] = 8'(i * 29 + 7);
        void'($urandom(21019));
        repeat (6) @(posedge clk);
        // outputs all zero while in reset
        q.push_back(ssx_note_t'(0));
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        run_op(1'b1, 0, 1'b0, 7'h00, 8'h00);
        run_op(1'b1, 1, 1'b1, 7'h05, 8'h00);
        for (int i = 0; i < 10; i++) run_op(1'b1, i % 6, i[0], 7'h02, 8'hFF);
        repeat (800) run_op($urandom_range(0, 7) != 0, $urandom_range(0, 5),
            1'($urandom), 7'($urandom_range(0, 7)), 8'($urandom));
        vld <= 1'b0;
        repeat (2) @(posedge clk);
        // mid-run reset: state back to zero, file array keeps its contents
        rst_n <= 1'b0;
        ew = 8'h00;
        ef = 3'h0;
        q.push_back(ssx_note_t'(0));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        repeat (100) run_op($urandom_range(0, 7) != 0, $urandom_range(0, 5),
            1'($urandom), 7'($urandom_range(0, 7)), 8'($urandom));
        vld <= 1'b0;
        repeat (2) @(posedge clk);
        report_and_stop();
    end
    initial begin
        #100000;
        fails++;
        report_and_stop();
    end
endmodule
